// ---- verilog/lhbp_port.sv ----
// host bus port: multiplexed parallel (two strobe styles) and serial access
`timescale 1ns/100ps

// Functional notes
// R1: serial out shifts on rising sclk when edge select low, falling when high.
// R2: separate-strobe mode drives read data on ad lines only while rd_n low.
// R3: data-strobe mode with rw at 0 samples ad lines as write data.
// R4: data-strobe mode with rw at 1 drives read data during data strobe.
// R5: parallel modes share ad lines for address and data; serial leaves them.
// R6: data strobe qualifies each read or write data phase after the address.
// R7: separate-strobe mode captures address on falling address latch strobe.
// R8: data-strobe mode latches address on falling address strobe.
// R9: data-strobe mode pulls ack_n low when read data valid or write accepted.
// R10: separate-strobe mode holds ready low during access, high when done.
// R11: ad drivers stay off whenever no read data phase is active.
module lhbp_port
  import lhbp_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   rstn,
  input  wire logic [1:0]             mode_sel,
  input  wire logic                   cs_n,
  input  wire logic [LHBP_DATA_W-1:0] ad_in,
  output logic      [LHBP_DATA_W-1:0] ad_out,
  output logic                        ad_oe,
  input  wire logic                   ale,
  input  wire logic                   rd_n,
  input  wire logic                   wr_n,
  output logic                        rdy,
  input  wire logic                   address_strobe_n,
  input  wire logic                   data_strobe_n,
  input  wire logic                   rw,
  output logic                        ack_n,
  input  wire logic                   sclk,
  input  wire logic                   sdi,
  input  wire logic                   serial_out_edge_select,
  output logic                        serial_out_line,
  output logic      [LHBP_DATA_W-1:0] reg_addr,
  output logic      [LHBP_DATA_W-1:0] reg_wdata,
  output logic                        reg_we,
  output logic                        reg_re,
  input  wire logic [LHBP_DATA_W-1:0] reg_rdata
);

  typedef struct packed {
    lhbp_state_t             st;
    logic                    ale_p;
    logic                    astb_p;
    logic                    dstb_p;
    logic                    rd_p;
    logic                    wr_p;
    logic                    sclk_p;
    logic [LHBP_DATA_W-1:0]  addr;
    logic [LHBP_DATA_W-1:0]  ad_out;
    logic                    ad_oe;
    logic                    rdy;
    logic                    ack_n;
    logic [LHBP_DATA_W-1:0]  reg_addr;
    logic [LHBP_DATA_W-1:0]  reg_wdata;
    logic                    reg_we;
    logic                    reg_re;
    logic                    sout;
    logic [LHBP_DATA_W-1:0]  in_sh;
    logic [LHBP_DATA_W-1:0]  out_sh;
    logic [4:0]              bitcnt;
    logic                    ser_rd;
  } lhbp_regs_t;

  lhbp_regs_t s_q;
  lhbp_regs_t s_d;

  logic sel_active;
  logic ale_fall;
  logic astb_fall;
  logic dstb_fall;
  logic dstb_rise;
  logic rd_fall;
  logic rd_rise;
  logic wr_fall;
  logic wr_rise;
  logic sclk_rise;
  logic sclk_fall;
  logic out_edge;
  logic [LHBP_DATA_W-1:0] hdr;

  assign sel_active = ~cs_n;
  assign ale_fall   = s_q.ale_p & ~ale;
  assign astb_fall  = s_q.astb_p & ~address_strobe_n;
  assign dstb_fall  = s_q.dstb_p & ~data_strobe_n;
  assign dstb_rise  = ~s_q.dstb_p & data_strobe_n;
  assign rd_fall    = s_q.rd_p & ~rd_n;
  assign rd_rise    = ~s_q.rd_p & rd_n;
  assign wr_fall    = s_q.wr_p & ~wr_n;
  assign wr_rise    = ~s_q.wr_p & wr_n;
  assign sclk_rise  = ~s_q.sclk_p & sclk;
  assign sclk_fall  = s_q.sclk_p & ~sclk;
  assign out_edge   = serial_out_edge_select ? sclk_fall : sclk_rise; // R1
  assign hdr        = {s_q.in_sh[LHBP_DATA_W-2:0], sdi};

  always_comb begin
    s_d        = s_q;
    s_d.ale_p  = ale;
    s_d.astb_p = address_strobe_n;
    s_d.dstb_p = data_strobe_n;
    s_d.rd_p   = rd_n;
    s_d.wr_p   = wr_n;
    s_d.sclk_p = sclk;
    s_d.reg_we = 1'b0;
    s_d.reg_re = 1'b0;
    case (mode_sel)
      LHBP_MODE_SEP: begin
        s_d.ack_n = LHBP_ACK_N_RST;
        if (sel_active && ale_fall) begin
          s_d.addr = ad_in; // R7
        end
        case (s_q.st)
          LHBP_IDLE: begin
            s_d.ad_oe = 1'b0; // R11
            if (sel_active && rd_fall) begin
              s_d.rdy      = 1'b0; // R10
              s_d.reg_addr = s_q.addr;
              s_d.reg_re   = 1'b1;
              s_d.st       = LHBP_RD_FETCH;
            end else if (sel_active && wr_fall) begin
              s_d.rdy = 1'b0; // R10
              s_d.st  = LHBP_WR_HOLD;
            end
          end
          LHBP_RD_FETCH: begin
            s_d.ad_out = reg_rdata;
            s_d.ad_oe  = ~rd_n; // R2
            s_d.rdy    = 1'b1; // R10
            s_d.st     = rd_n ? LHBP_IDLE : LHBP_RD_DRIVE;
          end
          LHBP_RD_DRIVE: begin
            if (rd_rise || rd_n) begin
              s_d.ad_oe = 1'b0; // R2
              s_d.st    = LHBP_IDLE;
            end
          end
          LHBP_WR_HOLD: begin
            if (wr_rise || wr_n) begin
              s_d.reg_addr  = s_q.addr;
              s_d.reg_wdata = ad_in;
              s_d.reg_we    = 1'b1;
              s_d.rdy       = 1'b1; // R10
              s_d.st        = LHBP_IDLE;
            end
          end
          default: begin
            s_d.st = LHBP_IDLE;
          end
        endcase
      end
      LHBP_MODE_DSTB: begin
        s_d.rdy = LHBP_RDY_RST;
        if (sel_active && astb_fall) begin
          s_d.addr = ad_in; // R8
        end
        case (s_q.st)
          LHBP_IDLE: begin
            s_d.ad_oe = 1'b0; // R11
            s_d.ack_n = LHBP_ACK_N_RST;
            if (sel_active && dstb_fall) begin // R6
              s_d.reg_addr = s_q.addr;
              if (rw) begin
                s_d.reg_re = 1'b1;
                s_d.st     = LHBP_RD_FETCH;
              end else begin
                s_d.reg_wdata = ad_in; // R3
                s_d.reg_we    = 1'b1;
                s_d.ack_n     = 1'b0; // R9
                s_d.st        = LHBP_WR_HOLD;
              end
            end
          end
          LHBP_RD_FETCH: begin
            s_d.ad_out = reg_rdata;
            s_d.ad_oe  = ~data_strobe_n; // R4
            s_d.ack_n  = data_strobe_n; // R9
            s_d.st     = data_strobe_n ? LHBP_IDLE : LHBP_RD_DRIVE;
          end
          LHBP_RD_DRIVE, LHBP_WR_HOLD: begin
            if (dstb_rise || data_strobe_n) begin
              s_d.ad_oe = 1'b0; // R11
              s_d.ack_n = 1'b1;
              s_d.st    = LHBP_IDLE;
            end
          end
          default: begin
            s_d.st = LHBP_IDLE;
          end
        endcase
      end
      LHBP_MODE_SER: begin
        s_d.ad_oe = 1'b0; // R5
        s_d.rdy   = LHBP_RDY_RST;
        s_d.ack_n = LHBP_ACK_N_RST;
        s_d.st    = LHBP_IDLE;
        if (s_q.reg_re) begin
          s_d.out_sh = reg_rdata;
        end
        if (!sel_active) begin
          s_d.bitcnt = LHBP_CNT_RST;
        end else begin
          if (sclk_rise && (s_q.bitcnt < 5'(LHBP_FRAME_BITS))) begin
            s_d.in_sh  = hdr;
            s_d.bitcnt = s_q.bitcnt + 5'h01;
            if (s_q.bitcnt == 5'(LHBP_HDR_BITS - 1)) begin
              s_d.ser_rd   = hdr[LHBP_DATA_W-1];
              s_d.reg_addr = {1'b0, hdr[LHBP_DATA_W-2:0]};
              s_d.reg_re   = hdr[LHBP_DATA_W-1];
            end
            if ((s_q.bitcnt == 5'(LHBP_FRAME_BITS - 1)) && !s_q.ser_rd) begin
              s_d.reg_wdata = hdr;
              s_d.reg_we    = 1'b1;
            end
          end
          if (out_edge && s_q.ser_rd && (s_q.bitcnt >= 5'(LHBP_HDR_BITS))) begin
            s_d.sout   = s_q.out_sh[LHBP_DATA_W-1]; // R1
            s_d.out_sh = {s_q.out_sh[LHBP_DATA_W-2:0], 1'b0};
          end
        end
      end
      default: begin
        s_d.ad_oe = 1'b0;
        s_d.rdy   = LHBP_RDY_RST;
        s_d.ack_n = LHBP_ACK_N_RST;
        s_d.st    = LHBP_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      s_q        <= '0;
      s_q.st     <= LHBP_IDLE;
      s_q.ale_p  <= 1'b0;
      s_q.astb_p <= 1'b1;
      s_q.dstb_p <= 1'b1;
      s_q.rd_p   <= 1'b1;
      s_q.wr_p   <= 1'b1;
      s_q.rdy    <= LHBP_RDY_RST;
      s_q.ack_n  <= LHBP_ACK_N_RST;
      s_q.addr   <= LHBP_BYTE_RST;
      s_q.bitcnt <= LHBP_CNT_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign ad_out          = s_q.ad_out;
  assign ad_oe           = s_q.ad_oe;
  assign rdy             = s_q.rdy;
  assign ack_n           = s_q.ack_n;
  assign serial_out_line = s_q.sout;
  assign reg_addr        = s_q.reg_addr;
  assign reg_wdata       = s_q.reg_wdata;
  assign reg_we          = s_q.reg_we;
  assign reg_re          = s_q.reg_re;

endmodule : lhbp_port

// ---- include/lhbp_pkg.sv ----
// shared constants and types for the line unit host bus port
package lhbp_pkg;

  localparam int unsigned LHBP_DATA_W      = 8;
  localparam int unsigned LHBP_HDR_BITS    = 8;
  localparam int unsigned LHBP_FRAME_BITS  = 16;

  // host port mode select encodings
  localparam logic [1:0]  LHBP_MODE_SEP    = 2'h0;
  localparam logic [1:0]  LHBP_MODE_DSTB   = 2'h1;
  localparam logic [1:0]  LHBP_MODE_SER    = 2'h2;

  // values after reset
  localparam logic [7:0]  LHBP_BYTE_RST    = 8'h00;
  localparam logic [4:0]  LHBP_CNT_RST     = 5'h00;
  localparam logic        LHBP_RDY_RST     = 1'b1;
  localparam logic        LHBP_ACK_N_RST   = 1'b1;

  typedef enum logic [1:0] {
    LHBP_IDLE,
    LHBP_RD_FETCH,
    LHBP_RD_DRIVE,
    LHBP_WR_HOLD
  } lhbp_state_t;

endpackage : lhbp_pkg

// ---- dv/lhbp_asserts.sv ----
// checker for the host bus port
`timescale 1ns/100ps
module lhbp_asserts
  import lhbp_pkg::*;
(
  input wire logic       clk,
  input wire logic       rstn,
  input wire logic [1:0] mode_sel,
  input wire logic       cs_n,
  input wire logic       rd_n,
  input wire logic       wr_n,
  input wire logic       data_strobe_n,
  input wire logic       rw,
  input wire logic       ad_oe,
  input wire logic       rdy,
  input wire logic       ack_n,
  input wire logic       reg_we,
  input wire logic       reg_re
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  wire sp = mode_sel == LHBP_MODE_SEP && !cs_n;
  wire dp = mode_sel == LHBP_MODE_DSTB && !cs_n;
  chk_sep_rd: assert property (sp && $fell(rd_n) |-> ##1 (!rdy && reg_re) ##1 (rdy && ad_oe))
    else $error("sep read");
  chk_sep_wr: assert property (sp && $rose(wr_n) && !rdy |=> reg_we && rdy)
    else $error("sep write");
  chk_rd_gate: assert property (ad_oe && mode_sel == LHBP_MODE_SEP |-> !$past(rd_n))
    else $error("rd drive");
  chk_dstb_rd: assert property (dp && $fell(data_strobe_n) && rw |-> ##1 reg_re ##1 (ad_oe && !ack_n))
    else $error("strobe read");
  chk_dstb_wr: assert property (dp && $fell(data_strobe_n) && !rw |=> reg_we && !ack_n)
    else $error("strobe write");
  chk_ack_hold: assert property (!ack_n && !data_strobe_n |=> !ack_n)
    else $error("ack drop");
  chk_oe_off: assert property (ad_oe && (mode_sel == LHBP_MODE_SEP ? rd_n : data_strobe_n) |=> !ad_oe)
    else $error("oe stuck");
  chk_ser_quiet: assert property (mode_sel == LHBP_MODE_SER |-> !ad_oe && rdy && ack_n)
    else $error("ser drive");
  cover property (sp && reg_re);
  cover property (dp && reg_we);
  cover property (mode_sel == LHBP_MODE_SER && reg_re);
endmodule : lhbp_asserts
bind lhbp_port lhbp_asserts u_chk (.clk, .rstn, .mode_sel, .cs_n, .rd_n, .wr_n, .data_strobe_n,
  .rw, .ad_oe, .rdy, .ack_n, .reg_we, .reg_re);

// ---- dv/lhbp_host.sv ----
// host model driving the parallel and serial pins
`timescale 1ns/100ps
module lhbp_host (
  input wire logic       clk,
  input wire logic [7:0] ad_out,
  input wire logic       ad_oe,
  input wire logic       ser_out,
  output logic     [7:0] ad_in,
  output logic           cs_n,
  output logic           ale,
  output logic           rd_n,
  output logic           wr_n,
  output logic           astb_n,
  output logic           dstb_n,
  output logic           rw,
  output logic           sclk,
  output logic           sdi
);
  logic       h_oe = 1'b1;
  logic [7:0] h_ad = 8'h00;
  initial {cs_n, ale, rd_n, wr_n, astb_n, dstb_n, rw, sclk, sdi} = 9'h178;
  // undriven lines show the inverse of the host's last value
  assign ad_in = h_oe ? h_ad : ad_oe ? ad_out : ~h_ad;
  task automatic par(input logic dstb, wr, input logic [7:0] a, d, output logic [7:0] q);
    @(negedge clk);
    {cs_n, ale, h_ad} = {1'b0, !dstb, a};
    @(negedge clk);
    {ale, astb_n} = {1'b0, !dstb};
    @(negedge clk);
    {h_ad, h_oe, rw} = {d, wr, !wr};
    if (dstb) dstb_n = 1'b0;
    else if (wr) wr_n = 1'b0;
    else rd_n = 1'b0;
    repeat (4) @(negedge clk);
    q = ad_in;
    {rd_n, wr_n, dstb_n, astb_n} = 4'hf;
    repeat (2) @(negedge clk);
    {h_oe, cs_n} = 2'h3;
  endtask : par
  task automatic ser(input logic sel, input logic [15:0] f, output logic [7:0] q);
    {h_oe, h_ad, cs_n} = 10'h1fe;
    for (int i = 0; i < 16; i++) begin
      @(negedge clk);
      sdi = f[15-i];
      repeat (3) @(negedge clk);
      if (sel && i > 7) q = {q[6:0], ser_out};
      sclk = 1'b1;
      repeat (3) @(negedge clk);
      if (!sel && i > 7) q = {q[6:0], ser_out};
      sclk = 1'b0;
    end
    repeat (3) @(negedge clk);
    {h_oe, cs_n} = 2'h3;
    // deselect must be seen for a clock so the next frame restarts its bit count
    @(negedge clk);
  endtask : ser
endmodule : lhbp_host

// ---- dv/lhbp_port_tb.sv ----
// self-checking bench for the host bus port
`timescale 1ns/100ps
module lhbp_port_tb
  import lhbp_pkg::*;
();
  logic       clk = 1'b0, rstn = 1'b0, sel = 1'b0;
  logic [1:0] mode_sel = LHBP_MODE_SEP;
  logic [7:0] ad_in, ad_out, reg_addr, reg_wdata, wa, wd, q;
  logic       ad_oe, rdy, ack_n, ser_out, reg_we, reg_re, cs_n, ale, rd_n, wr_n, rw;
  logic       sclk, sdi, astb_n, dstb_n;
  int         mismatches = 0;
  int         comparisons = 0;
  initial forever #25 clk = ~clk;
  lhbp_port u_dut (.clk, .rstn, .mode_sel, .cs_n, .ad_in, .ad_out, .ad_oe, .ale, .rd_n, .wr_n,
    .rdy, .address_strobe_n(astb_n), .data_strobe_n(dstb_n), .rw, .ack_n, .sclk, .sdi,
    .serial_out_edge_select(sel), .serial_out_line(ser_out), .reg_addr, .reg_wdata, .reg_we,
    .reg_re, .reg_rdata(reg_addr ^ 8'h5a));
  lhbp_host u_host (.clk, .ad_out, .ad_oe, .ser_out, .ad_in, .cs_n, .ale, .rd_n, .wr_n, .astb_n,
    .dstb_n, .rw, .sclk, .sdi);
  always @(posedge clk) if (reg_we) {wa, wd} <= {reg_addr, reg_wdata};
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : complete_run
  task automatic sep_back_to_back();
    mode_sel = LHBP_MODE_SEP;
    u_host.par(1'b0, 1'b1, 8'h81, 8'h3c, q);
    check({wa, wd}, 16'h813c);
    u_host.par(1'b0, 1'b0, 8'hfe, 8'h00, q);
    check({8'h00, q}, 16'h00a4);
  endtask : sep_back_to_back
  task automatic dstb_back_to_back();
    mode_sel = LHBP_MODE_DSTB;
    u_host.par(1'b1, 1'b1, 8'h7f, 8'hc3, q);
    check({wa, wd}, 16'h7fc3);
    u_host.par(1'b1, 1'b0, 8'h00, 8'h00, q);
    check({8'h00, q}, 16'h005a);
  endtask : dstb_back_to_back
  task automatic serial_both_edges();
    mode_sel = LHBP_MODE_SER;
    for (int s = 0; s < 2; s++) begin
      sel = s[0];
      u_host.ser(sel, 16'h55a6, q);
      check({wa, wd}, 16'h55a6);
      u_host.ser(sel, 16'hab00, q);
      check({8'h00, q}, 16'h0071);
    end
  endtask : serial_both_edges
  task automatic disabled_port();
    mode_sel = 2'h3;
    u_host.par(1'b0, 1'b0, 8'h10, 8'h00, q);
    check({8'h00, q}, 16'h00ff);
  endtask : disabled_port
  initial begin
    repeat (12) @(negedge clk);
    rstn = 1'b1;
    repeat (2) @(negedge clk);
    sep_back_to_back();
    dstb_back_to_back();
    serial_both_edges();
    disabled_port();
    complete_run();
  end
endmodule : lhbp_port_tb
